// ===== rtl/fperc_pkg.sv
package fperc_pkg;

	// Register byte offsets on the Avalon slave
	localparam logic [3:0] ADDR_SC_CTRL = 4'h0;  // Scalar control word
	localparam logic [3:0] ADDR_SC_STAT = 4'h4;  // Scalar status word
	localparam logic [3:0] ADDR_SD_CSR  = 4'h8;  // SIMD control/status
	localparam logic [3:0] ADDR_EVENT   = 4'hC;  // Block state, read only

	// Field positions inside the words
	localparam int SC_RC_LO   = 10;  // Scalar rounding field, bits 11:10
	localparam int SD_RC_LO   = 13;  // SIMD rounding field, bits 14:13
	localparam int SC_MASK_LO = 0;   // Scalar masks, control bits 5:0
	localparam int SD_MASK_LO = 7;   // SIMD masks, bits 12:7
	localparam int FLAG_LO    = 0;   // Flags, bits 5:0 in both places
	localparam int EV_BUSY    = 0;   // Event word: operation in flight
	localparam int EV_TRAP    = 1;   // Event word: last answer was a trap
	localparam int EV_ENV     = 2;   // Event word: last environment

	// Exception bit order inside every flag and mask field
	localparam int EXC_INVALID   = 0;
	localparam int EXC_DENORMAL  = 1;
	localparam int EXC_DIVZERO   = 2;
	localparam int EXC_OVERFLOW  = 3;
	localparam int EXC_UNDERFLOW = 4;
	localparam int EXC_INEXACT   = 5;

	// Rounding field encodings
	localparam logic [1:0] RC_NEAREST = 2'h0;  // Ties to even
	localparam logic [1:0] RC_DOWN    = 2'h1;  // Toward minus infinity
	localparam logic [1:0] RC_UP      = 2'h2;  // Toward plus infinity
	localparam logic [1:0] RC_ZERO    = 2'h3;  // Truncate

	// Reset values
	localparam logic [1:0] RC_RESET   = 2'h0;   // Round to nearest
	localparam logic [5:0] MASK_RESET = 6'h3F;  // All exceptions masked
	localparam logic [5:0] FLAG_RESET = 6'h00;  // No exceptions seen

	// Operation sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PRE_RESP,
		ST_WAIT_POST,
		ST_POST_RESP
	} fperc_state_e;

endpackage : fperc_pkg

// ===== rtl/fperc_exc_ctrl.sv
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/100ps
module fperc_exc_ctrl (
	input  wire logic        clk,             // Core clock, 40 MHz
	input  wire logic        reset,           // Synchronous, active high
	input  wire logic [3:0]  avs_address,     // Byte address of the word
	input  wire logic        avs_read,        // Read request
	input  wire logic        avs_write,       // Write request
	input  wire logic [31:0] avs_writedata,   // Write data
	output logic      [31:0] avs_readdata,    // Read data
	output logic             avs_waitrequest, // Stall the master
	input  wire logic        op_start,        // New operation, one pulse
	input  wire logic        op_env,          // 0 scalar stack, 1 SIMD
	input  wire logic        op_trunc_cvt,    // Truncating conversion
	input  wire logic        op_no_round,     // Compare, exact or NaN
	input  wire logic [2:0]  pre_cond,        // Denormal, div0, invalid
	input  wire logic        post_valid,      // Result computed, pulse
	input  wire logic [2:0]  post_cond,       // Inexact, under, over
	output logic      [1:0]  rnd_mode,        // Rounding for this op
	output logic             resp_valid,      // Response pulse
	output logic             resp_default,    // Substitute default result
	output logic             resp_indef,      // Write indefinite value
	output logic             resp_trap,       // Invoke software handler
	output logic             resp_keep_ops,   // Leave operands unaltered
	output logic             resp_post        // Go on to compute result
);

	// Whole block state in one word
	typedef struct packed {
		logic [1:0]             sc_rc;      // Scalar rounding field
		logic [5:0]             sc_mask;    // Scalar mask bits
		logic [5:0]             sc_flag;    // Scalar sticky flags
		logic [1:0]             sd_rc;      // SIMD rounding field
		logic [5:0]             sd_mask;    // SIMD mask bits
		logic [5:0]             sd_flag;    // SIMD sticky flags
		fperc_pkg::fperc_state_e state;     // Operation sequencer
		logic                   cur_env;    // Environment of the op
		logic [5:0]             cur_exc;    // Conditions of this phase
		logic                   last_trap;  // Last answer was a trap
		logic                   waitreq;    // Bus stall
		logic [31:0]            rdata;      // Bus read data
		logic [1:0]             rnd;        // Rounding mode out
		logic                   r_valid;    // Response pulse
		logic                   r_default;  // Default result
		logic                   r_indef;    // Indefinite value
		logic                   r_trap;     // Handler request
		logic                   r_keep;     // Operands untouched
		logic                   r_post;     // Continue to post phase
	} fperc_state_s;

	fperc_state_s q;       // Registered state
	fperc_state_s d;       // Next state
	logic         wr_fire; // Write accepted this edge
	logic [31:0]  rd_mux;  // Word that a read returns
	logic [5:0]   pre_vec; // Pre conditions in flag order
	logic [5:0]   post_vec;// Post conditions in flag order
	logic [5:0]   sc_set;  // Scalar flags raised this cycle
	logic [5:0]   sd_set;  // SIMD flags raised this cycle
	logic [5:0]   unmasked;// Latched conditions with mask clear

	// Write takes effect at the edge where waitrequest is low
	assign wr_fire = avs_write && !q.waitreq;

	// Spread the datapath conditions onto the flag layout
	always_comb begin
		pre_vec = 6'h00;
		post_vec = 6'h00;
		pre_vec[fperc_pkg::EXC_INVALID]  = pre_cond[0];
		pre_vec[fperc_pkg::EXC_DIVZERO]  = pre_cond[1];
		pre_vec[fperc_pkg::EXC_DENORMAL] = pre_cond[2];
		post_vec[fperc_pkg::EXC_OVERFLOW]  = post_cond[0];
		post_vec[fperc_pkg::EXC_UNDERFLOW] = post_cond[1];
		// no-round ops report no rounding inexactness
		post_vec[fperc_pkg::EXC_INEXACT]   = post_cond[2] && !op_no_round;
	end

	// Read multiplexer; unmapped words and reserved bits read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (avs_address)
			fperc_pkg::ADDR_SC_CTRL: begin
				rd_mux[fperc_pkg::SC_RC_LO +: 2] = q.sc_rc;
				rd_mux[fperc_pkg::SC_MASK_LO +: 6] = q.sc_mask;
			end
			fperc_pkg::ADDR_SC_STAT: begin
				rd_mux[fperc_pkg::FLAG_LO +: 6] = q.sc_flag;
			end
			fperc_pkg::ADDR_SD_CSR: begin
				rd_mux[fperc_pkg::SD_RC_LO +: 2] = q.sd_rc;
				rd_mux[fperc_pkg::SD_MASK_LO +: 6] = q.sd_mask;
				rd_mux[fperc_pkg::FLAG_LO +: 6] = q.sd_flag;
			end
			fperc_pkg::ADDR_EVENT: begin
				rd_mux[fperc_pkg::EV_BUSY] = (q.state != fperc_pkg::ST_IDLE);
				rd_mux[fperc_pkg::EV_TRAP] = q.last_trap;
				rd_mux[fperc_pkg::EV_ENV] = q.cur_env;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	// Masks of the op's own environment against its conditions
	// mask choice follows the environment
	assign unmasked = q.cur_exc & ~(q.cur_env ? q.sd_mask : q.sc_mask);

	// Next-state logic: bus, flags, sequencer
	always_comb begin
		d = q;
		sc_set = 6'h00;
		sd_set = 6'h00;
		// Response outputs are pulses
		d.r_valid = 1'b0;
		d.r_default = 1'b0;
		d.r_indef = 1'b0;
		d.r_trap = 1'b0;
		d.r_keep = 1'b0;
		d.r_post = 1'b0;

		// Two-cycle handshake: stall once, then answer
		if ((avs_read || avs_write) && q.waitreq) begin
			d.waitreq = 1'b0;
			d.rdata = rd_mux;
		end else begin
			d.waitreq = 1'b1;
		end

		// Software writes
		if (wr_fire) begin
			case (avs_address)
				fperc_pkg::ADDR_SC_CTRL: begin
					d.sc_rc = avs_writedata[fperc_pkg::SC_RC_LO +: 2];
					d.sc_mask = avs_writedata[fperc_pkg::SC_MASK_LO +: 6];
				end
				fperc_pkg::ADDR_SC_STAT: begin
					d.sc_flag = avs_writedata[fperc_pkg::FLAG_LO +: 6];
				end
				fperc_pkg::ADDR_SD_CSR: begin
					d.sd_rc = avs_writedata[fperc_pkg::SD_RC_LO +: 2];
					d.sd_mask = avs_writedata[fperc_pkg::SD_MASK_LO +: 6];
					d.sd_flag = avs_writedata[fperc_pkg::FLAG_LO +: 6];
				end
				default: begin
					// Read-only or unmapped: write ignored
					d.sd_flag = d.sd_flag;
				end
			endcase
		end

		// Operation sequencer
		case (q.state)
			fperc_pkg::ST_IDLE: begin
				if (op_start) begin
					d.cur_env = op_env;
					d.cur_exc = pre_vec;
					d.state = fperc_pkg::ST_PRE_RESP;
					if (op_env) begin
						sd_set = pre_vec;
					end else begin
						sc_set = pre_vec;
					end
					if (op_env && op_trunc_cvt) begin
						d.rnd = fperc_pkg::RC_ZERO;
					// no-round ops get a fixed neutral mode
					end else if (op_no_round) begin
						d.rnd = fperc_pkg::RC_NEAREST;
					// each environment uses its own field
					end else begin
						// field code used as the mode
						d.rnd = op_env ? q.sd_rc : q.sc_rc;
					end
				end
			end
			fperc_pkg::ST_PRE_RESP: begin
				d.r_valid = 1'b1;
				if (unmasked != 6'h00) begin
					d.r_trap = 1'b1;
					d.r_keep = 1'b1;
					d.last_trap = 1'b1;
					d.state = fperc_pkg::ST_IDLE;
				end else begin
					d.r_default = (q.cur_exc != 6'h00);
					d.r_indef = q.cur_exc[fperc_pkg::EXC_INVALID];
					d.r_post = 1'b1;
					d.last_trap = 1'b0;
					d.state = fperc_pkg::ST_WAIT_POST;
				end
			end
			fperc_pkg::ST_WAIT_POST: begin
				// New ops are ignored until the result arrives
				if (post_valid) begin
					d.cur_exc = post_vec;
					d.state = fperc_pkg::ST_POST_RESP;
					// overflow, underflow and inexact flags of the op's environment
					if (q.cur_env) begin
						sd_set = post_vec;
					end else begin
						sc_set = post_vec;
					end
				end
			end
			fperc_pkg::ST_POST_RESP: begin
				d.r_valid = 1'b1;
				d.state = fperc_pkg::ST_IDLE;
				if (unmasked != 6'h00) begin
					d.r_trap = 1'b1;
					d.r_keep = 1'b1;
					d.last_trap = 1'b1;
				end else begin
					d.r_default = (q.cur_exc != 6'h00);
					d.last_trap = 1'b0;
				end
			end
			default: begin
				d.state = fperc_pkg::ST_IDLE;
			end
		endcase

		// sticky accumulate; a set beats a same-cycle clear
		d.sc_flag = d.sc_flag | sc_set;
		d.sd_flag = d.sd_flag | sd_set;
	end

	// State register
	always_ff @(posedge clk) begin
		if (reset) begin
			q.sc_rc <= fperc_pkg::RC_RESET;
			q.sc_mask <= fperc_pkg::MASK_RESET;
			q.sc_flag <= fperc_pkg::FLAG_RESET;
			q.sd_rc <= fperc_pkg::RC_RESET;
			q.sd_mask <= fperc_pkg::MASK_RESET;
			q.sd_flag <= fperc_pkg::FLAG_RESET;
			q.state <= fperc_pkg::ST_IDLE;
			q.cur_env <= 1'b0;
			q.cur_exc <= 6'h00;
			q.last_trap <= 1'b0;
			q.waitreq <= 1'b1;
			q.rdata <= 32'h0000_0000;
			q.rnd <= fperc_pkg::RC_RESET;
			q.r_valid <= 1'b0;
			q.r_default <= 1'b0;
			q.r_indef <= 1'b0;
			q.r_trap <= 1'b0;
			q.r_keep <= 1'b0;
			q.r_post <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign avs_readdata = q.rdata;
	assign avs_waitrequest = q.waitreq;
	assign rnd_mode = q.rnd;
	assign resp_valid = q.r_valid;
	assign resp_default = q.r_default;
	assign resp_indef = q.r_indef;
	assign resp_trap = q.r_trap;
	assign resp_keep_ops = q.r_keep;
	assign resp_post = q.r_post;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// Accepted scalar operation start
	sequence s_start_sc;
		q.state == fperc_pkg::ST_IDLE && op_start && !op_env;
	endsequence

	// Scalar invalid with its mask clear, other mask bits unconstrained
	sequence s_sc_inv_unmasked;
		s_start_sc ##0 pre_cond[0] && !q.sc_mask[fperc_pkg::EXC_INVALID];
	endsequence

	property p_pre_flag;
		s_start_sc ##0 pre_cond[0] |=> q.sc_flag[fperc_pkg::EXC_INVALID];
	endproperty
	a_pre_flag: assert property (p_pre_flag)
		else $error("scalar invalid flag not set after start");

	property p_unmasked_trap;
		s_sc_inv_unmasked ##0 !wr_fire |-> ##2 resp_trap && resp_keep_ops;
	endproperty
	a_unmasked_trap: assert property (p_unmasked_trap)
		else $error("unmasked invalid did not trap");

	property p_masked_indef;
		s_start_sc ##0 pre_cond[0] && q.sc_mask == 6'h3F && !wr_fire
			|-> ##2 resp_indef && resp_valid && !resp_trap;
	endproperty
	a_masked_indef: assert property (p_masked_indef)
		else $error("masked invalid gave no indefinite value");

	property p_sticky;
		!wr_fire |=> (q.sc_flag & $past(q.sc_flag)) == $past(q.sc_flag)
			&& (q.sd_flag & $past(q.sd_flag)) == $past(q.sd_flag);
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("flag dropped without a software write");

	property p_trunc;
		q.state == fperc_pkg::ST_IDLE && op_start && op_env && op_trunc_cvt
			|=> rnd_mode == fperc_pkg::RC_ZERO;
	endproperty
	a_trunc: assert property (p_trunc)
		else $error("truncating conversion not rounding to zero");

	property p_sc_round;
		s_start_sc ##0 !op_trunc_cvt && !op_no_round
			|=> rnd_mode == $past(q.sc_rc);
	endproperty
	a_sc_round: assert property (p_sc_round)
		else $error("scalar op used wrong rounding field");

	property p_post_inexact;
		q.state == fperc_pkg::ST_WAIT_POST && post_valid && post_cond[2]
			&& !op_no_round && q.cur_env
			|=> q.sd_flag[fperc_pkg::EXC_INEXACT] ##1 resp_valid;
	endproperty
	a_post_inexact: assert property (p_post_inexact)
		else $error("inexact flag or post answer missing");

	property p_simd_isolated;
		q.state == fperc_pkg::ST_IDLE && op_start && op_env && !wr_fire
			|=> $stable(q.sc_flag);
	endproperty
	a_simd_isolated: assert property (p_simd_isolated)
		else $error("SIMD op touched scalar flags");

	property p_bus_answer;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_bus_answer: assert property (p_bus_answer)
		else $error("bus request not answered in one cycle");

endmodule : fperc_exc_ctrl

// ===== tb/fperc_tb_top.sv
`timescale 1ns/100ps
// Compare one value, count it, report a mismatch
`define CHK(n, e, g) begin num_checks++; if ((e) !== (g)) begin fails++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
	logic        clk = 1'b0;             // Core clock, 25 ns
	logic        reset = 1'b1;           // Held two cycles
	logic [3:0]  avs_address = 4'h0;     // Bus address
	logic        avs_read = 1'b0;        // Bus read
	logic        avs_write = 1'b0;       // Bus write
	logic [31:0] avs_writedata = 32'h0;  // Bus write data
	logic [31:0] avs_readdata;           // Bus read data
	logic        avs_waitrequest;        // Bus stall
	logic        op_start = 1'b0;        // Operation pulse
	logic        op_env = 1'b0;          // Environment select
	logic        op_trunc_cvt = 1'b0;    // Truncating conversion
	logic        op_no_round = 1'b0;     // Rounding-free op
	logic [2:0]  pre_cond = 3'h0;        // Pre-computation conditions
	logic        post_valid = 1'b0;      // Result computed
	logic [2:0]  post_cond = 3'h0;       // Post-computation conditions
	logic [1:0]  rnd_mode;               // Rounding out
	logic        resp_valid, resp_default, resp_indef;
	logic        resp_trap, resp_keep_ops, resp_post;
	int          fails = 0;              // Mismatches
	int          num_checks = 0;         // Comparisons made
	int          cyc = 0;                // Timeout counter
	int          seed = 18;              // Fixed random seed
	logic [31:0] r;                      // Random word
	logic [1:0]  m_rc [2];               // Model rounding fields
	logic [5:0]  m_mask [2];             // Model masks
	logic [5:0]  m_flag [2];             // Model sticky flags
	logic        m_trap, m_env;          // Model event word
	logic [6:0]  rsp_q [$];              // Expected responses
	logic [31:0] rd_q [$];               // Expected read data
	logic [6:0]  e;                      // Popped response
	logic [31:0] x;                      // Popped read word
	logic [6:0]  seen;                   // Response outputs together

	// Response outputs in the order of the queued notes
	assign seen = {rnd_mode, resp_trap, resp_keep_ops, resp_default,
		resp_indef, resp_post};

	fperc_exc_ctrl DUT (.clk(clk), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .op_start(op_start),
		.op_env(op_env), .op_trunc_cvt(op_trunc_cvt),
		.op_no_round(op_no_round), .pre_cond(pre_cond),
		.post_valid(post_valid), .post_cond(post_cond), .rnd_mode(rnd_mode),
		.resp_valid(resp_valid), .resp_default(resp_default),
		.resp_indef(resp_indef), .resp_trap(resp_trap),
		.resp_keep_ops(resp_keep_ops), .resp_post(resp_post));

	// Free-running clock
	always #12.5 clk = ~clk;

	// Verdict and end of run
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	// Hang guard, far above the fewer than one thousand cycles needed
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			finish_test();
		end
	end

	// Expected word at an address, from the model
	function automatic logic [31:0] exp_rd(input logic [3:0] a);
		case (a)
			fperc_pkg::ADDR_SC_CTRL: exp_rd = {20'h0, m_rc[0], 4'h0, m_mask[0]};
			fperc_pkg::ADDR_SC_STAT: exp_rd = {26'h0, m_flag[0]};
			fperc_pkg::ADDR_SD_CSR:
				exp_rd = {17'h0, m_rc[1], m_mask[1], 1'b0, m_flag[1]};
			fperc_pkg::ADDR_EVENT: exp_rd = {29'h0, m_env, m_trap, 1'b0};
			default: exp_rd = 32'h0;  // Unmapped reads zero
		endcase
	endfunction : exp_rd

	// One Avalon access; request held until waitrequest seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		// No cycle count assumed; only the hang guard ends a wait
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	// Read with the expectation queued first
	task automatic rd(input logic [3:0] a);
		rd_q.push_back(exp_rd(a));
		bus(1'b0, a, 32'h0);
	endtask : rd

	// Write, then mirror it into the model
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		case (a)
			fperc_pkg::ADDR_SC_CTRL: begin
				m_rc[0] = d[11:10];
				m_mask[0] = d[5:0];
			end
			fperc_pkg::ADDR_SC_STAT: m_flag[0] = d[5:0];
			fperc_pkg::ADDR_SD_CSR: begin
				m_rc[1] = d[14:13];
				m_mask[1] = d[12:7];
				m_flag[1] = d[5:0];
			end
			default: ;  // Read-only or unmapped: no effect
		endcase
	endtask : wr

	// One operation; sp injects a stray start while waiting
	task automatic op(input logic env, input logic tc, input logic nr,
		input logic [2:0] pc, input logic sp, input logic [2:0] qc);
		logic [5:0] f;
		logic [1:0] rm;
		logic       t;
		rm = (env && tc) ? fperc_pkg::RC_ZERO :
			(nr ? fperc_pkg::RC_NEAREST : m_rc[env]);
		f = {3'h0, pc[1], pc[2], pc[0]};
		m_flag[env] |= f;
		t = |(f & ~m_mask[env]);
		rsp_q.push_back({rm, t, t, !t && |f, !t && pc[0], !t});
		m_trap = t;
		m_env = env;
		@(posedge clk);
		op_start <= 1'b1;
		op_env <= env;
		op_trunc_cvt <= tc;
		op_no_round <= nr;
		pre_cond <= pc;
		@(posedge clk);
		op_start <= 1'b0;
		// Trap ends the op; otherwise the result phase follows
		if (!t) begin
			repeat (2) @(posedge clk);
			if (sp) begin
				op_start <= 1'b1;
				@(posedge clk);
				op_start <= 1'b0;
			end
			f = {qc[2] && !nr, qc[1], qc[0], 3'h0};
			m_flag[env] |= f;
			t = |(f & ~m_mask[env]);
			m_trap = t;
			rsp_q.push_back({rm, t, t, !t && |f, 2'h0});
			@(posedge clk);
			post_valid <= 1'b1;
			post_cond <= qc;
			@(posedge clk);
			post_valid <= 1'b0;
		end
		repeat (4) @(posedge clk);
	endtask : op

	// Output watcher: oldest note against each result
	always @(posedge clk) begin
		if (resp_valid === 1'b1) begin
			if (rsp_q.size() == 0) begin
				fails++;
				$display("ERROR resp_valid exp 0 got 1");
			end else begin
				e = rsp_q.pop_front();
				`CHK("response", e, seen)
			end
		end
		// Pop once; the macro names its expected value twice
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rd_q.size() > 0)
		begin
			x = rd_q.pop_front();
			`CHK("readdata", x, avs_readdata)
		end
	end

	// Main sequence
	initial begin
		m_rc = '{2'h0, 2'h0};
		m_mask = '{6'h3F, 6'h3F};
		m_flag = '{6'h00, 6'h00};
		m_trap = 1'b0;
		m_env = 1'b0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		// Reset values and an unmapped place
		rd(fperc_pkg::ADDR_SC_CTRL);
		rd(fperc_pkg::ADDR_SC_STAT);
		rd(fperc_pkg::ADDR_SD_CSR);
		rd(fperc_pkg::ADDR_EVENT);
		rd(4'h2);
		// Every encoding, opposite values in the two fields
		for (int i = 0; i < 4; i++) begin
			wr(fperc_pkg::ADDR_SC_CTRL, {20'h0, i[1:0], 10'h3F});
			wr(fperc_pkg::ADDR_SD_CSR, {17'h0, ~i[1:0], 13'h1F80});
			rd(fperc_pkg::ADDR_SD_CSR);
			op(1'b0, 1'b0, 1'b0, 3'h0, 1'b0, 3'h0);
			op(1'b1, 1'b0, 1'b0, 3'h0, 1'b0, 3'h0);
			op(1'b1, 1'b1, 1'b0, 3'h0, 1'b0, 3'h4);
			op(1'b0, 1'b1, 1'b0, 3'h0, 1'b0, 3'h0);
			op(1'b0, 1'b0, 1'b1, 3'h0, 1'b0, 3'h0);
		end
		// Masked invalid and denormal, then underflow and inexact
		wr(fperc_pkg::ADDR_SC_CTRL, 32'h3F);
		op(1'b0, 1'b0, 1'b0, 3'h5, 1'b0, 3'h6);
		rd(fperc_pkg::ADDR_SC_STAT);
		// Clean op with a stray start; flags must stay
		op(1'b0, 1'b0, 1'b0, 3'h0, 1'b1, 3'h0);
		rd(fperc_pkg::ADDR_SC_STAT);
		rd(fperc_pkg::ADDR_SD_CSR);
		// Unmasked divide-by-zero traps the scalar unit only
		wr(fperc_pkg::ADDR_SC_CTRL, 32'h0);
		op(1'b0, 1'b0, 1'b0, 3'h2, 1'b0, 3'h0);
		op(1'b0, 1'b0, 1'b0, 3'h1, 1'b0, 3'h0);
		rd(fperc_pkg::ADDR_EVENT);
		wr(fperc_pkg::ADDR_EVENT, 32'hFF);
		rd(fperc_pkg::ADDR_EVENT);
		op(1'b1, 1'b0, 1'b0, 3'h2, 1'b0, 3'h0);
		// Unmasked overflow traps after the result
		wr(fperc_pkg::ADDR_SD_CSR, 32'h0);
		op(1'b1, 1'b0, 1'b0, 3'h0, 1'b0, 3'h1);
		rd(fperc_pkg::ADDR_EVENT);
		// Stray result pulse while idle is ignored
		@(posedge clk);
		post_valid <= 1'b1;
		post_cond <= 3'h7;
		@(posedge clk);
		post_valid <= 1'b0;
		repeat (4) @(posedge clk);
		rd(fperc_pkg::ADDR_SD_CSR);
		// Explicit write clears flags
		wr(fperc_pkg::ADDR_SC_STAT, 32'h0);
		rd(fperc_pkg::ADDR_SC_STAT);
		// Random masks, fields, conditions and environments
		repeat (16) begin
			r = $random(seed);
			wr(fperc_pkg::ADDR_SC_CTRL, {20'h0, r[1:0], 4'h0, r[7:2]});
			wr(fperc_pkg::ADDR_SD_CSR, {17'h0, r[9:8], r[15:10], 7'h0});
			op(r[16], r[17], r[18], r[21:19], r[22],
				{r[23] & !r[18], r[25:24]});
			rd(fperc_pkg::ADDR_SC_STAT);
			rd(fperc_pkg::ADDR_SD_CSR);
			rd(fperc_pkg::ADDR_EVENT);
		end
		repeat (4) @(posedge clk);
		if (rsp_q.size() != 0) begin
			fails++;
			$display("ERROR pending responses exp 0 got %0d", rsp_q.size());
		end
		finish_test();
	end
endmodule : tb_top
